// *** arar_top.sv ***
// Range select and alarm status register bank with APB slave, interrupt and frame tail.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module arar_top #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic app_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_done,
    input wire logic cmp_input_high,
    input wire logic cmp_input_low,
    input wire logic cmp_supply_high,
    input wire logic cmp_supply_low,
    output logic [3:0] range_code,
    output logic range_bipolar,
    output logic reference_off,
    output logic [3:0] active_alarms,
    output logic [3:0] latched_alarms,
    output logic [5:0] frame_tail_bits,
    output logic [2:0] frame_tail_len,
    output logic irq
);

    // All control and bus answer state of the bank.
    typedef struct packed {
        logic [3:0] range_code;
        logic range_bipolar;
        logic reference_off;
        logic [1:0] frame_input_alarm_select;
        logic frame_range_code_append;
        logic [3:0] irq_status;
        logic [3:0] irq_enable;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } arar_top_state_type;

    // The decoder needs the full low byte of the address, so narrower buses are refused when the design is built.
    if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_width
        $error("arar_top: ADDR_WIDTH must lie between 8 and 32.");
    end

    arar_top_state_type state_q;
    arar_top_state_type state_d;
    arar_alarm_if alarm_bus ();

    logic setup_phase;
    logic access_done;
    logic [7:0] offset;
    logic high_addr_zero;
    logic mapped;
    logic [31:0] read_word;
    logic [31:0] alarm_word;

    // A transfer is answered in the access cycle that directly follows its setup cycle.
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & state_q.pready;
    assign offset = paddr[7:0];

    // Address bits above the low byte must be zero for any register to answer.
    if (ADDR_WIDTH > 8) begin : g_high
        assign high_addr_zero = (paddr[ADDR_WIDTH-1:8] == '0);
    end else begin : g_nohigh
        assign high_addr_zero = 1'b1;
    end

    // Alarm status word; every bit not listed stays zero.
    always_comb begin
        alarm_word = 32'h0000_0000;
        alarm_word[arar_pkg::ACTIVE_SUPPLY_LOW_BIT] = alarm_bus.active[arar_pkg::ALARM_SUPPLY_LOW];
        alarm_word[arar_pkg::ACTIVE_SUPPLY_HIGH_BIT] = alarm_bus.active[arar_pkg::ALARM_SUPPLY_HIGH];
        alarm_word[arar_pkg::ACTIVE_INPUT_LOW_BIT] = alarm_bus.active[arar_pkg::ALARM_INPUT_LOW];
        alarm_word[arar_pkg::ACTIVE_INPUT_HIGH_BIT] = alarm_bus.active[arar_pkg::ALARM_INPUT_HIGH];
        alarm_word[arar_pkg::LATCHED_SUPPLY_LOW_BIT] = alarm_bus.latched[arar_pkg::ALARM_SUPPLY_LOW];
        alarm_word[arar_pkg::LATCHED_SUPPLY_HIGH_BIT] = alarm_bus.latched[arar_pkg::ALARM_SUPPLY_HIGH];
        alarm_word[arar_pkg::LATCHED_INPUT_LOW_BIT] = alarm_bus.latched[arar_pkg::ALARM_INPUT_LOW];
        alarm_word[arar_pkg::LATCHED_INPUT_HIGH_BIT] = alarm_bus.latched[arar_pkg::ALARM_INPUT_HIGH];
        alarm_word[arar_pkg::ANY_LATCHED_ALARM_BIT] = |alarm_bus.latched;
    end

    // Read multiplexer and address decode; unmapped offsets answer with an error and zero data.
    always_comb begin
        read_word = 32'h0000_0000;
        mapped = high_addr_zero;
        if (offset == arar_pkg::RANGE_CTRL_OFFSET) begin
            read_word[arar_pkg::RANGE_CODE_LSB +: 4] = state_q.range_code;
            read_word[arar_pkg::REFERENCE_OFF_BIT] = state_q.reference_off;
        end else if (offset == arar_pkg::ALARM_STATUS_OFFSET) begin
            read_word = alarm_word;
        end else if (offset == arar_pkg::FRAME_CTRL_OFFSET) begin
            read_word[arar_pkg::FRAME_RANGE_APPEND_BIT] = state_q.frame_range_code_append;
            read_word[arar_pkg::FRAME_ALARM_SELECT_LSB +: 2] = state_q.frame_input_alarm_select;
        end else if (offset == arar_pkg::IRQ_STATUS_OFFSET) begin
            read_word[3:0] = state_q.irq_status;
        end else if (offset == arar_pkg::IRQ_CLEAR_OFFSET) begin
            read_word = 32'h0000_0000;
        end else if (offset == arar_pkg::IRQ_ENABLE_OFFSET) begin
            read_word[3:0] = state_q.irq_enable;
        end else begin
            mapped = 1'b0;
        end
        if (!high_addr_zero) begin
            read_word = 32'h0000_0000;
        end
    end

    // Next state of the bank: bus answer, register writes, interrupt bits and application reset.
    always_comb begin
        state_d = state_q;
        state_d.pready = setup_phase;
        state_d.pslverr = setup_phase & ~mapped;
        if (setup_phase) begin
            state_d.prdata = pwrite ? 32'h0000_0000 : read_word;
        end
        if (access_done && pwrite && mapped) begin
            if (offset == arar_pkg::RANGE_CTRL_OFFSET && pstrb[0]) begin
                state_d.reference_off = pwdata[arar_pkg::REFERENCE_OFF_BIT];
                // Undefined codes would leave the front end in an untrimmed state, so they are dropped.
                if (arar_pkg::arar_range_valid(pwdata[arar_pkg::RANGE_CODE_LSB +: 4])) begin
                    state_d.range_code = pwdata[arar_pkg::RANGE_CODE_LSB +: 4];
                    state_d.range_bipolar = arar_pkg::arar_range_bipolar(
                        pwdata[arar_pkg::RANGE_CODE_LSB +: 4]);
                end
            end else if (offset == arar_pkg::FRAME_CTRL_OFFSET && pstrb[1]) begin
                state_d.frame_range_code_append = pwdata[arar_pkg::FRAME_RANGE_APPEND_BIT];
                state_d.frame_input_alarm_select = pwdata[arar_pkg::FRAME_ALARM_SELECT_LSB +: 2];
            end else if (offset == arar_pkg::IRQ_CLEAR_OFFSET && pstrb[0]) begin
                state_d.irq_status = state_q.irq_status & ~pwdata[3:0];
            end else if (offset == arar_pkg::IRQ_ENABLE_OFFSET && pstrb[0]) begin
                state_d.irq_enable = pwdata[3:0];
            end
        end
        // A trip in the cycle of a clear still sets its bit.
        state_d.irq_status = state_d.irq_status | alarm_bus.tripped_event;
        // Application reset clears the reference bit and the frame controls, never the range code.
        if (app_reset) begin
            state_d.reference_off = arar_pkg::REFERENCE_OFF_RESET;
            state_d.frame_range_code_append = 1'b0;
            state_d.frame_input_alarm_select = 2'h0;
        end
        state_d.irq = |(state_d.irq_status & state_d.irq_enable);
    end

    // Power-on reset puts every field to its value after reset.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= '0;
            state_q.range_code <= arar_pkg::RANGE_CODE_RESET;
            state_q.range_bipolar <= 1'b1;
            state_q.reference_off <= arar_pkg::REFERENCE_OFF_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Comparison results and clears toward the flag keeper; a completed read of the alarm word clears tripped flags.
    assign alarm_bus.conv_done = conv_done;
    assign alarm_bus.compare = {cmp_supply_low, cmp_supply_high, cmp_input_low, cmp_input_high};
    assign alarm_bus.read_clear = access_done & ~pwrite & high_addr_zero
        & (offset == arar_pkg::ALARM_STATUS_OFFSET);
    assign alarm_bus.app_clear = app_reset;

    arar_alarm_flags arar_alarm_flags_inst (
        .clock(clock),
        .rst(rst),
        .alarm(alarm_bus.keeper)
    );

    arar_frame_tail arar_frame_tail_inst (
        .clock(clock),
        .rst(rst),
        .conv_done(conv_done),
        .range_code(state_q.range_code),
        .range_append(state_q.frame_range_code_append),
        .alarm_select(state_q.frame_input_alarm_select),
        .active_input_high(alarm_bus.compare[arar_pkg::ALARM_INPUT_HIGH]),
        .active_input_low(alarm_bus.compare[arar_pkg::ALARM_INPUT_LOW]),
        .tail_bits(frame_tail_bits),
        .tail_len(frame_tail_len)
    );

    // Outputs straight from the state flip-flops.
    assign prdata = state_q.prdata;
    assign pready = state_q.pready;
    assign pslverr = state_q.pslverr;
    assign range_code = state_q.range_code;
    assign range_bipolar = state_q.range_bipolar;
    assign reference_off = state_q.reference_off;
    assign active_alarms = alarm_bus.active;
    assign latched_alarms = alarm_bus.latched;
    assign irq = state_q.irq;

endmodule

// *** arar_pkg.sv ***
// Package with register map, field positions, reset values and shared types of the range and alarm register bank.
package arar_pkg;

    // Byte addresses of the documented registers.
    localparam logic [7:0] RANGE_CTRL_OFFSET = 8'h14;
    localparam logic [7:0] ALARM_STATUS_OFFSET = 8'h20;
    // Byte addresses of the frame, interrupt status, clear and enable registers.
    localparam logic [7:0] FRAME_CTRL_OFFSET = 8'h10;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h30;
    localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h34;
    localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h38;

    // Field positions of the range and reference control register.
    localparam int RANGE_CODE_LSB = 0;
    localparam int REFERENCE_OFF_BIT = 6;
    // Field positions of the frame control register.
    localparam int FRAME_RANGE_APPEND_BIT = 8;
    localparam int FRAME_ALARM_SELECT_LSB = 10;
    // Field positions of the alarm status register.
    localparam int ACTIVE_SUPPLY_LOW_BIT = 15;
    localparam int ACTIVE_SUPPLY_HIGH_BIT = 14;
    localparam int ACTIVE_INPUT_LOW_BIT = 11;
    localparam int ACTIVE_INPUT_HIGH_BIT = 10;
    localparam int LATCHED_SUPPLY_LOW_BIT = 7;
    localparam int LATCHED_SUPPLY_HIGH_BIT = 6;
    localparam int LATCHED_INPUT_LOW_BIT = 5;
    localparam int LATCHED_INPUT_HIGH_BIT = 4;
    localparam int ANY_LATCHED_ALARM_BIT = 0;

    // Index of each alarm inside the four-bit flag vectors.
    localparam int ALARM_INPUT_HIGH = 0;
    localparam int ALARM_INPUT_LOW = 1;
    localparam int ALARM_SUPPLY_HIGH = 2;
    localparam int ALARM_SUPPLY_LOW = 3;

    // Values after reset.
    localparam logic [3:0] RANGE_CODE_RESET = 4'h0;
    localparam logic REFERENCE_OFF_RESET = 1'b0;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

    // Frame select encodings for the input alarm flags.
    localparam logic [1:0] FRAME_SELECT_HIGH = 2'h1;
    localparam logic [1:0] FRAME_SELECT_LOW = 2'h2;
    localparam logic [1:0] FRAME_SELECT_BOTH = 2'h3;

    // State of the alarm flag keeper.
    typedef struct packed {
        logic [3:0] active;
        logic [3:0] latched;
    } arar_flag_state_type;

    // State of the frame tail builder.
    typedef struct packed {
        logic [5:0] tail_bits;
        logic [2:0] tail_len;
    } arar_tail_state_type;

    // Nine defined range codes: bipolar 0..4, unipolar 8..11.
    function automatic logic arar_range_valid(input logic [3:0] code);
        arar_range_valid = (code <= 4'h4) || ((code >= 4'h8) && (code <= 4'hb));
    endfunction

    // The top bit of a defined code marks a unipolar range.
    function automatic logic arar_range_bipolar(input logic [3:0] code);
        arar_range_bipolar = ~code[3];
    endfunction

endpackage

// *** arar_alarm_if.sv ***
// Interface carrying comparison results and alarm flags between the register top and the flag keeper.
`timescale 1ns/1ps
interface arar_alarm_if;
    logic conv_done;
    logic [3:0] compare;
    logic read_clear;
    logic app_clear;
    logic [3:0] active;
    logic [3:0] latched;
    logic [3:0] tripped_event;

    modport keeper (
        input conv_done,
        input compare,
        input read_clear,
        input app_clear,
        output active,
        output latched,
        output tripped_event
    );

    modport user (
        output conv_done,
        output compare,
        output read_clear,
        output app_clear,
        input active,
        input latched,
        input tripped_event
    );
endinterface

// *** arar_alarm_flags.sv ***
// Alarm flag keeper: live flags per conversion and sticky tripped flags.
`timescale 1ns/1ps
module arar_alarm_flags (
    input wire logic clock,
    input wire logic rst,
    arar_alarm_if.keeper alarm
);
    arar_pkg::arar_flag_state_type state_q;
    arar_pkg::arar_flag_state_type state_d;

    // Active flags follow each conversion; tripped flags hold, and a new trip beats a read clear.
    always_comb begin
        state_d = state_q;
        if (alarm.conv_done) begin
            state_d.active = alarm.compare;
        end
        state_d.latched = state_q.latched & ~{4{alarm.read_clear | alarm.app_clear}};
        if (alarm.conv_done) begin
            state_d.latched = state_d.latched | alarm.compare;
        end
        if (alarm.app_clear) begin
            state_d.active = arar_pkg::FLAGS_RESET;
        end
    end

    // Every flag starts with no alarm condition.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // A trip event marks a flag that becomes newly set, for the interrupt logic.
    assign alarm.tripped_event = {4{alarm.conv_done}} & alarm.compare & ~state_q.latched;
    assign alarm.active = state_q.active;
    assign alarm.latched = state_q.latched;
endmodule

// *** arar_frame_tail.sv ***
// Frame tail builder: the fields appended to each serial output frame.
`timescale 1ns/1ps
module arar_frame_tail (
    input wire logic clock,
    input wire logic rst,
    input wire logic conv_done,
    input wire logic [3:0] range_code,
    input wire logic range_append,
    input wire logic [1:0] alarm_select,
    input wire logic active_input_high,
    input wire logic active_input_low,
    output logic [5:0] tail_bits,
    output logic [2:0] tail_len
);
    arar_pkg::arar_tail_state_type state_q;
    arar_pkg::arar_tail_state_type state_d;

    // Fields are shifted in order range code, high flag, low flag; the last lands at bit 0.
    always_comb begin
        state_d = state_q;
        if (conv_done) begin
            state_d.tail_bits = 6'h00;
            state_d.tail_len = 3'h0;
            if (range_append) begin
                state_d.tail_bits = {2'h0, range_code};
                state_d.tail_len = 3'h4;
            end
            if (alarm_select[0]) begin
                state_d.tail_bits = {state_d.tail_bits[4:0], active_input_high};
                state_d.tail_len = state_d.tail_len + 3'h1;
            end
            if (alarm_select[1]) begin
                state_d.tail_bits = {state_d.tail_bits[4:0], active_input_low};
                state_d.tail_len = state_d.tail_len + 3'h1;
            end
        end
    end

    // The tail is refreshed once per conversion and held between them.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign tail_bits = state_q.tail_bits;
    assign tail_len = state_q.tail_len;
endmodule

// *** arar_properties.sv ***
// Concurrent checks on the ports of the range and alarm register bank.
`timescale 1ns/1ps
module arar_properties #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic app_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic conv_done,
    input wire logic cmp_input_high,
    input wire logic cmp_input_low,
    input wire logic cmp_supply_high,
    input wire logic cmp_supply_low,
    input wire logic [3:0] range_code,
    input wire logic range_bipolar,
    input wire logic reference_off,
    input wire logic [3:0] active_alarms,
    input wire logic [3:0] latched_alarms
);
    logic rd_range;
    logic rd_alarm;
    // Completing read of each register; the address is held through the access phase.
    assign rd_range = psel && penable && pready && !pwrite && paddr == arar_pkg::RANGE_CTRL_OFFSET;
    assign rd_alarm = psel && penable && pready && !pwrite && paddr == arar_pkg::ALARM_STATUS_OFFSET;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    a_range_ready: assert property (psel && !penable && paddr == arar_pkg::RANGE_CTRL_OFFSET
        |=> pready && !pslverr)
        else $error("range register access not answered cleanly");
    a_reserved_zero: assert property (rd_range |-> prdata[31:7] == 25'h0 && prdata[5:4] == 2'h0)
        else $error("reserved range bits not zero");
    // Guarded against an application reset at the setup edge, which may change the field being read.
    a_range_readback: assert property (rd_range && !$past(app_reset)
        |-> prdata[3:0] == range_code && prdata[6] == reference_off)
        else $error("range readback differs from outputs");
    a_bipolar_map: assert property (range_bipolar == !range_code[3])
        else $error("bipolar flag wrong for code");
    a_code_defined: assert property (range_code <= 4'h4 || (range_code >= 4'h8 && range_code <= 4'hb))
        else $error("undefined range code held");
    a_app_keeps_code: assert property (app_reset && !(psel && penable && pwrite)
        |=> range_code == $past(range_code) && !reference_off)
        else $error("application reset handled wrongly");
    a_alarm_active: assert property (rd_alarm && !$past(conv_done)
        |-> prdata[15:14] == $past(active_alarms[3:2]) && prdata[11:10] == $past(active_alarms[1:0]))
        else $error("active flags misplaced");
    a_any_is_or: assert property (rd_alarm |-> prdata[0] == (|prdata[7:4]) && prdata[31:16] == 16'h0)
        else $error("summary bit is not the OR of tripped flags");
    a_read_clears: assert property (rd_alarm && !conv_done |=> latched_alarms == 4'h0)
        else $error("status read did not clear tripped flags");
    a_active_follows: assert property (conv_done && !app_reset |=> active_alarms ==
        {$past(cmp_supply_low), $past(cmp_supply_high), $past(cmp_input_low), $past(cmp_input_high)})
        else $error("active flags do not follow comparison");
endmodule

// *** arar_host.sv ***
// Host model: APB master that the bench steers through its transfer task.
`timescale 1ns/1ps
module arar_host (
    input wire logic clock,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    // Bus idle from time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
    end

    // One transfer; an idle edge follows so that no signal is assigned twice in one step.
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
endmodule

// *** arar_top_bench.sv ***
// Self-checking bench for the range and alarm register bank.
`timescale 1ns/1ps
module arar_top_bench;
    logic clock, rst, app_reset, conv_done, psel, penable, pwrite, pready, pslverr;
    logic range_bipolar, reference_off, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [3:0] cmp, v, range_code, active_alarms, latched_alarms;
    logic [5:0] tail_bits;
    logic [2:0] tail_len;
    logic [32:0] notes[$];
    logic [3:0] codes[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb};
    int miscompares = 0;
    int checked = 0;

    arar_top arar_top_inst (.clock(clock), .rst(rst), .app_reset(app_reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_done(conv_done), .cmp_input_high(cmp[0]), .cmp_input_low(cmp[1]),
        .cmp_supply_high(cmp[2]), .cmp_supply_low(cmp[3]), .range_code(range_code),
        .range_bipolar(range_bipolar), .reference_off(reference_off), .active_alarms(active_alarms),
        .latched_alarms(latched_alarms), .frame_tail_bits(tail_bits), .frame_tail_len(tail_len), .irq(irq));
    arar_host arar_host_inst (.clock(clock), .pready(pready), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    // Free-running 125 MHz clock.
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Expected status word: active flags in the upper byte, tripped flags and their OR below.
    function automatic logic [31:0] alarm_word(input logic [3:0] a, input logic [3:0] l);
        return {16'h0, a[3:2], 2'h0, a[1:0], 2'h0, l, 3'h0, |l};
    endfunction

    task automatic chk_rd(input logic [32:0] exp);
        checked++;
        if ({pslverr, prdata} !== exp) begin
            miscompares++;
            $display("[FAIL] %0t read got %h want %h", $time, {pslverr, prdata}, exp);
        end
    endtask

    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t output got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        arar_host_inst.xfer(1'b1, a, x);
    endtask

    // The expectation is queued before the request so the watcher always finds it.
    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        notes.push_back(exp);
        arar_host_inst.xfer(1'b0, a, 32'h0);
    endtask

    task automatic conv(input logic [3:0] c);
        conv_done <= 1'b1;
        cmp <= c;
        @(posedge clock);
        conv_done <= 1'b0;
        @(posedge clock);
    endtask

    task automatic results;
        // A read whose note was never taken off the queue counts as a mismatch.
        miscompares += notes.size();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watcher: each completed read is matched against the oldest queued note.
    always @(posedge clock) begin
        if (psel && penable && !pwrite && pready === 1'b1 && notes.size() > 0) begin
            chk_rd(notes.pop_front());
        end
    end

    // Watchdog, well beyond the few hundred cycles the sequence needs.
    initial begin
        #100000;
        miscompares++;
        results();
    end

    initial begin
        rst = 1'b1;
        app_reset = 1'b0;
        conv_done = 1'b0;
        cmp = 4'h0;
        void'($urandom(32'hbc6c));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(8'h14, 33'h0);
        rd(8'h20, 33'h0);
        chk_out(range_bipolar, 32'h1);
        // Every defined code, with random reserved bits and reference control.
        foreach (codes[i]) begin
            d = $urandom;
            d[3:0] = codes[i];
            wr(8'h14, d);
            rd(8'h14, {26'h0, d[6], 2'h0, codes[i]});
            chk_out(range_bipolar, {31'h0, !codes[i][3]});
        end
        wr(8'h14, 32'h45);
        rd(8'h14, 33'h4b);
        app_reset <= 1'b1;
        @(posedge clock);
        app_reset <= 1'b0;
        @(posedge clock);
        chk_out(reference_off, 32'h0);
        rd(8'h14, 33'hb);
        wr(8'h10, 32'hd00);
        wr(8'h38, 32'hf);
        // Trip, read, trip again, then let the comparisons go quiet.
        repeat (4) begin
            v = 4'($urandom % 15 + 1);
            conv(v);
            chk_out({tail_len, tail_bits}, {23'h0, 3'h6, 4'hb, v[0], v[1]});
            chk_out(irq, 32'h1);
            rd(8'h20, {1'b0, alarm_word(v, v)});
            conv(v);
            conv(4'h0);
            chk_out({active_alarms, latched_alarms}, {24'h0, 4'h0, v});
            rd(8'h20, {1'b0, alarm_word(4'h0, v)});
            rd(8'h20, 33'h0);
        end
        // Each input flag alone, without the range code in front of it.
        wr(8'h10, 32'h400);
        conv(v);
        chk_out({tail_len, tail_bits}, {23'h0, 3'h1, 5'h0, v[0]});
        wr(8'h10, 32'h800);
        conv(v);
        chk_out({tail_len, tail_bits}, {23'h0, 3'h1, 5'h0, v[1]});
        wr(8'h38, 32'h0);
        chk_out(irq, 32'h0);
        wr(8'h38, 32'hf);
        chk_out(irq, 32'h1);
        wr(8'h34, 32'hf);
        chk_out(irq, 32'h0);
        rd(8'h40, {1'b1, 32'h0});
        results();
    end
endmodule

bind arar_top arar_properties #(.ADDR_WIDTH(ADDR_WIDTH)) arar_properties_inst (.clock(clock), .rst(rst),
    .app_reset(app_reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_done(conv_done), .cmp_input_high(cmp_input_high),
    .cmp_input_low(cmp_input_low), .cmp_supply_high(cmp_supply_high), .cmp_supply_low(cmp_supply_low),
    .range_code(range_code), .range_bipolar(range_bipolar), .reference_off(reference_off),
    .active_alarms(active_alarms), .latched_alarms(latched_alarms));
